// >>> ocp_cfg.svh
// Purpose: Offsets, reset values, field positions and step sizes for the
//          output clock phase register bank.
// Assumes: Register offsets are register indices; byte address is 4x index.
// Notes:   Definitions only.
`ifndef OCP_CFG_SVH
`define OCP_CFG_SVH

// Register indices.
`define OCP_IDX_QUAD 8'h53
`define OCP_IDX_APLL_FINE 8'h55
`define OCP_IDX_DIFF_CTRL 8'h60
`define OCP_IDX_DIFF_SEL 8'h61
`define OCP_IDX_COMB_FINE 8'h63
`define OCP_IDX_PAGE 8'h64

// Reset values.
`define OCP_RST_QUAD 8'h00
`define OCP_RST_APLL_FINE 8'h00
`define OCP_RST_DIFF_CTRL 8'ha3
`define OCP_RST_DIFF_SEL 8'h55
`define OCP_RST_COMB_FINE 8'hff
`define OCP_RST_PAGE 8'h00

// Field positions.
`define OCP_QUAD_MSB 1
`define OCP_QUAD_LSB 0
`define OCP_DIFF_EN_BIT 1
`define OCP_SKEW_MSB 7
`define OCP_SKEW_LSB 6
`define OCP_FSEL_MSB 6
`define OCP_FSEL_LSB 4

// Page selector codes.
`define OCP_PG_GENERAL 8'h00
`define OCP_PG_OSC 8'h01
`define OCP_PG_SYNC1HZ 8'h08
`define OCP_PG_TOD 8'h0a
`define OCP_PG_INTSTAT 8'h0f

// Step sizes: fine trim in tenths of a picosecond, skew in picoseconds.
`define OCP_FINE_STEP_TENTH_PS 12'h4a8
`define OCP_SKEW_STEP_PS 12'h640

// Bus constants.
`define OCP_HRESP_OKAY 1'b0
`define OCP_WORD_SHIFT 2
`define OCP_IDX_BITS 8

`endif

// >>> ocp_field_map.sv
// Purpose: Turns the raw register bytes into clock path control values.
// Assumes: Purely combinational; the caller registers the results.
// Notes:   Trims are signed; skew delay grows with the code.
`timescale 1ns/10ps
`include "ocp_cfg.svh"

module ocp_field_map
  import ocp_pkg::*;
(
  // Register bytes.
  input wire ocp_byte_t quad_byte_i,
  input wire ocp_byte_t apll_fine_i,
  input wire ocp_byte_t diff_ctrl_i,
  input wire ocp_byte_t diff_sel_i,
  input wire ocp_byte_t comb_fine_i,
  input wire ocp_byte_t page_i,
  // Decoded controls.
  output logic [3:0] quad_onehot_o,
  output ocp_trim_t apll_trim_o,
  output ocp_trim_t comb_trim_o,
  output logic diff_drive_o,
  output logic [1:0] skew_code_o,
  output ocp_skew_ps_t skew_ps_o,
  output logic [2:0] freq_sel_o,
  output ocp_page_t page_o
);

  wire [1:0] quad_code_w = quad_byte_i[`OCP_QUAD_MSB:`OCP_QUAD_LSB];

  // Coarse quadrant: codes 0..3 give 0, 90, 180, 270 degrees.
  assign quad_onehot_o = 4'h1 << quad_code_w;

  // Fine trims: signed step count times the step size.
  assign apll_trim_o = ocp_trim_t'($signed(apll_fine_i)) *
                       ocp_trim_t'(`OCP_FINE_STEP_TENTH_PS);
  assign comb_trim_o = ocp_trim_t'($signed(comb_fine_i)) *
                       ocp_trim_t'(`OCP_FINE_STEP_TENTH_PS);

  // Differential output controls.
  assign diff_drive_o = diff_ctrl_i[`OCP_DIFF_EN_BIT];
  assign skew_code_o = diff_ctrl_i[`OCP_SKEW_MSB:`OCP_SKEW_LSB];
  // Lower code means less delay, so the output moves earlier.
  assign skew_ps_o = ocp_skew_ps_t'(skew_code_o) *
                     ocp_skew_ps_t'(`OCP_SKEW_STEP_PS);
  assign freq_sel_o = diff_sel_i[`OCP_FSEL_MSB:`OCP_FSEL_LSB];

  // Page decode; any other code is reserved.
  assign page_o = (page_i == `OCP_PG_GENERAL) ? OCP_PAGE_GENERAL :
                  (page_i == `OCP_PG_OSC) ? OCP_PAGE_OSC :
                  (page_i == `OCP_PG_SYNC1HZ) ? OCP_PAGE_SYNC1HZ :
                  (page_i == `OCP_PG_TOD) ? OCP_PAGE_TOD :
                  (page_i == `OCP_PG_INTSTAT) ? OCP_PAGE_INTSTAT :
                  OCP_PAGE_RESERVED;

endmodule : ocp_field_map

// >>> ocp_output_clock_phase_regs.sv
// Purpose: AHB-Lite register bank steering the output clock phase path.
// Assumes: Single word transfers; zero wait states; low byte carries data.
// Notes:   Clock controls follow a register write by two clock edges.
`timescale 1ns/10ps
`include "ocp_cfg.svh"

module ocp_output_clock_phase_regs
  import ocp_pkg::*;
#(
  parameter int HADDR_W = 12
)
(
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // AHB-Lite slave.
  input wire logic hsel_i,
  input wire logic [HADDR_W-1:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  // Single-ended clock phase.
  output logic [3:0] quad_phase_o,
  output logic [7:0] apll_trim_code_o,
  output ocp_trim_t apll_trim_o,
  output logic [7:0] comb_trim_code_o,
  output ocp_trim_t comb_trim_o,
  // Differential clock.
  output logic diff_oe_o,
  output logic [1:0] diff_skew_o,
  output ocp_skew_ps_t diff_skew_ps_o,
  output logic [2:0] diff_freq_sel_o,
  // Extended page.
  output logic [7:0] page_sel_o,
  output ocp_page_t page_o,
  output logic page_reserved_o
);

  localparam int NREG = 6;
  localparam int E_QUAD = 0;
  localparam int E_APLL = 1;
  localparam int E_DCTL = 2;
  localparam int E_DSEL = 3;
  localparam int E_COMB = 4;
  localparam int E_PAGE = 5;

  // The index needs bits 9:2 of the address, so narrower buses cannot work.
  if (HADDR_W < 10) begin : g_bad_width
    $error("HADDR_W must be at least 10");
  end

  // Index of each entry in the bank.
  function automatic logic [7:0] idx_of(input int e);
    case (e)
      E_QUAD: idx_of = `OCP_IDX_QUAD;
      E_APLL: idx_of = `OCP_IDX_APLL_FINE;
      E_DCTL: idx_of = `OCP_IDX_DIFF_CTRL;
      E_DSEL: idx_of = `OCP_IDX_DIFF_SEL;
      E_COMB: idx_of = `OCP_IDX_COMB_FINE;
      default: idx_of = `OCP_IDX_PAGE;
    endcase
  endfunction : idx_of

  // Reset value of each entry.
  function automatic ocp_byte_t rst_of(input int e);
    case (e)
      E_QUAD: rst_of = `OCP_RST_QUAD;
      E_APLL: rst_of = `OCP_RST_APLL_FINE;
      E_DCTL: rst_of = `OCP_RST_DIFF_CTRL;
      E_DSEL: rst_of = `OCP_RST_DIFF_SEL;
      E_COMB: rst_of = `OCP_RST_COMB_FINE;
      default: rst_of = `OCP_RST_PAGE;
    endcase
  endfunction : rst_of

  // Address phase decode.
  wire addr_take_w = hsel_i & hready_i & htrans_i[1];
  wire [7:0] addr_idx_w = haddr_i[`OCP_IDX_BITS+1:`OCP_WORD_SHIFT];
  wire addr_hi_zero_w = ((haddr_i >> (`OCP_IDX_BITS + 2)) == '0);
  wire addr_lo_zero_w = (haddr_i[1:0] == 2'h0);

  // Data phase state held from the address phase.
  logic wr_pend_reg;
  logic [7:0] wr_idx_reg;
  logic wr_ok_reg;

  // Register bank.
  ocp_byte_t regs_reg [NREG];
  ocp_byte_t regs_next [NREG];
  logic [NREG-1:0] addr_hit_w;
  logic [NREG-1:0] wr_hit_w;

  // Per entry: decode, next value and storage. Reserved bits are stored as
  // written so that their defaults read back unchanged.
  for (genvar e = 0; e < NREG; e++) begin : g_reg
    assign addr_hit_w[e] = (addr_idx_w == idx_of(e));
    assign wr_hit_w[e] = wr_pend_reg & wr_ok_reg & (wr_idx_reg == idx_of(e));
    assign regs_next[e] = wr_hit_w[e] ? hwdata_i[7:0] : regs_reg[e];
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        regs_reg[e] <= rst_of(e);
      end else begin
        regs_reg[e] <= regs_next[e];
      end
    end
  end

  // Read mux. It looks at the next values so that a read right behind a
  // write to the same register already sees the new byte.
  wire addr_ok_w = addr_hi_zero_w & addr_lo_zero_w;
  wire map_hit_w = addr_ok_w & (|addr_hit_w);
  logic [7:0] rd_byte_w;
  always_comb begin
    rd_byte_w = 8'h00;
    for (int e = 0; e < NREG; e++) begin
      if (addr_hit_w[e]) begin
        rd_byte_w = regs_next[e];
      end
    end
  end
  wire [31:0] rd_word_w = map_hit_w ? {24'h000000, rd_byte_w} : 32'h00000000;
  wire rd_take_w = addr_take_w & ~hwrite_i;

  // Address phase capture for the following data phase.
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= 8'h00;
      wr_ok_reg <= 1'b0;
    end else begin
      wr_pend_reg <= addr_take_w & hwrite_i;
      wr_idx_reg <= addr_idx_w;
      wr_ok_reg <= addr_ok_w;
    end
  end

  // Bus answer: never stalls, always OKAY; unmapped reads return zero.
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hreadyout_o <= 1'b1;
      hresp_o <= `OCP_HRESP_OKAY;
      hrdata_o <= 32'h00000000;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o <= `OCP_HRESP_OKAY;
      if (rd_take_w) begin
        hrdata_o <= rd_word_w;
      end
    end
  end

  // Field decode of the stored bytes.
  logic [3:0] quad_w;
  ocp_trim_t apll_trim_w;
  ocp_trim_t comb_trim_w;
  logic diff_drive_w;
  logic [1:0] skew_w;
  ocp_skew_ps_t skew_ps_w;
  logic [2:0] fsel_w;
  ocp_page_t page_w;

  ocp_field_map u_map (
    .quad_byte_i (regs_reg[E_QUAD]),
    .apll_fine_i (regs_reg[E_APLL]),
    .diff_ctrl_i (regs_reg[E_DCTL]),
    .diff_sel_i (regs_reg[E_DSEL]),
    .comb_fine_i (regs_reg[E_COMB]),
    .page_i (regs_reg[E_PAGE]),
    .quad_onehot_o (quad_w),
    .apll_trim_o (apll_trim_w),
    .comb_trim_o (comb_trim_w),
    .diff_drive_o (diff_drive_w),
    .skew_code_o (skew_w),
    .skew_ps_o (skew_ps_w),
    .freq_sel_o (fsel_w),
    .page_o (page_w)
  );

  // Registered clock path controls. The extra stage keeps the outputs clean
  // of decode glitches at the cost of one cycle of latency. Reset shows the
  // decoded default bytes, so that no control jumps when reset is released.
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      quad_phase_o <= 4'h1;
      apll_trim_code_o <= `OCP_RST_APLL_FINE;
      apll_trim_o <= '0;
      comb_trim_code_o <= `OCP_RST_COMB_FINE;
      comb_trim_o <= 19'h7fb58; // Minus one step, as the default byte says.
      diff_oe_o <= 1'b1;
      diff_skew_o <= 2'h2;
      diff_skew_ps_o <= 13'hc80;
      diff_freq_sel_o <= 3'h5;
    end else begin
      quad_phase_o <= quad_w;
      apll_trim_code_o <= regs_reg[E_APLL];
      apll_trim_o <= apll_trim_w;
      comb_trim_code_o <= regs_reg[E_COMB];
      comb_trim_o <= comb_trim_w;
      diff_oe_o <= diff_drive_w;
      diff_skew_o <= skew_w;
      diff_skew_ps_o <= skew_ps_w;
      diff_freq_sel_o <= fsel_w;
    end
  end

  // Page outputs. A reserved code is flagged, not corrected, since software
  // owns the choice of page.
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      page_sel_o <= `OCP_RST_PAGE;
      page_o <= OCP_PAGE_GENERAL;
      page_reserved_o <= 1'b0;
    end else begin
      page_sel_o <= regs_reg[E_PAGE];
      page_o <= page_w;
      page_reserved_o <= (page_w == OCP_PAGE_RESERVED);
    end
  end

  // Checks on the decoded controls, the page selector write and the bus answer.
  AST_QUAD_POSITION: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    (regs_reg[E_QUAD][1:0] == 2'h2) ##1 1'b1 |-> quad_phase_o == 4'h4)
    else $error("Quadrant code 2 did not select 180 degrees.");

  AST_APLL_TRIM: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    apll_trim_o == ocp_trim_t'($signed(apll_trim_code_o)) * 19'sd1192)
    else $error("Analog path trim does not match its code.");

  AST_DIFF_ENABLE: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    wr_hit_w[E_DCTL] |-> ##2 diff_oe_o == $past(hwdata_i[1], 2))
    else $error("Differential enable did not follow the write.");

  AST_SKEW_STEP: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    diff_skew_ps_o == {11'h000, diff_skew_o} * 13'd1600)
    else $error("Differential skew is not 1.6 ns per step.");

  AST_SKEW_ORDER: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    (diff_skew_o > $past(diff_skew_o)) |->
      (diff_skew_ps_o > $past(diff_skew_ps_o)))
    else $error("A larger skew code did not delay the output.");

  AST_FREQ_SELECT: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    wr_hit_w[E_DSEL] |-> ##2 diff_freq_sel_o == $past(hwdata_i[6:4], 2))
    else $error("Frequency select did not follow the write.");

  AST_COMB_TRIM: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    comb_trim_o == ocp_trim_t'($signed(comb_trim_code_o)) * 19'sd1192)
    else $error("Combined trim does not match its code.");

  AST_PAGE_LOW: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    (page_sel_o == 8'h01) |-> (page_o == OCP_PAGE_OSC) && !page_reserved_o)
    else $error("Page 01 did not select the oscillator page.");

  AST_PAGE_HIGH: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    (page_sel_o == 8'h0a) |-> (page_o == OCP_PAGE_TOD))
    else $error("Page 0A did not select the time of day page.");

  AST_PAGE_RESERVED: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    page_reserved_o == !(page_sel_o inside {8'h00, 8'h01, 8'h08, 8'h0a,
                                            8'h0f}))
    else $error("Reserved page code was not flagged.");

  AST_WRITE_TAKE: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    wr_hit_w[E_PAGE] |=> regs_reg[E_PAGE] == $past(hwdata_i[7:0]))
    else $error("Page selector write was lost.");

  AST_BUS_UNMAPPED: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    (rd_take_w && !map_hit_w) |=> hrdata_o == 32'h00000000
      && hreadyout_o && !hresp_o)
    else $error("Unmapped read did not return zero OKAY.");

endmodule : ocp_output_clock_phase_regs

// >>> ocp_pkg.sv
// Purpose: Types shared by the output clock phase register bank.
// Assumes: Nothing beyond the configuration header.
// Notes:   Constants live in ocp_cfg.svh.
package ocp_pkg;

  // One register byte.
  typedef logic [7:0] ocp_byte_t;

  // Signed trim, in tenths of a picosecond.
  typedef logic signed [18:0] ocp_trim_t;

  // Skew delay in picoseconds.
  typedef logic [12:0] ocp_skew_ps_t;

  // Decoded extended page.
  typedef enum logic [2:0] {
    OCP_PAGE_GENERAL,
    OCP_PAGE_OSC,
    OCP_PAGE_SYNC1HZ,
    OCP_PAGE_TOD,
    OCP_PAGE_INTSTAT,
    OCP_PAGE_RESERVED
  } ocp_page_t;

endpackage : ocp_pkg

// >>> output_clock_phase_regs_test.sv
// Purpose: Self-checking bench for the output clock phase register bank.
// Assumes: Zero wait slave; controls follow a write within two edges.
// Notes:   A bus monitor checks read data against a queue of expectations.
`timescale 1ns/10ps
`include "ocp_cfg.svh"

module output_clock_phase_regs_test
  import ocp_pkg::*;
;
  // Bus and clock stimulus.
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic hsel_i = 1'b0;
  logic hwrite_i = 1'b0;
  logic [11:0] haddr_i = 12'h000;
  logic [1:0] htrans_i = 2'h0;
  logic [2:0] hsize_i = 3'h2;
  logic [31:0] hwdata_i = 32'h0;
  // Design outputs.
  logic hreadyout_o, hresp_o, diff_oe_o, page_reserved_o;
  logic [31:0] hrdata_o;
  logic [3:0] quad_phase_o;
  logic [7:0] apll_trim_code_o, comb_trim_code_o, page_sel_o;
  ocp_trim_t apll_trim_o, comb_trim_o;
  logic [1:0] diff_skew_o;
  ocp_skew_ps_t diff_skew_ps_o;
  logic [2:0] diff_freq_sel_o;
  ocp_page_t page_o;
  // Bench state: register model, expectation queue, counters.
  localparam logic [7:0] IDX [6] = '{`OCP_IDX_QUAD, `OCP_IDX_APLL_FINE,
    `OCP_IDX_DIFF_CTRL, `OCP_IDX_DIFF_SEL, `OCP_IDX_COMB_FINE, `OCP_IDX_PAGE};
  localparam logic [7:0] DFT [6] = '{`OCP_RST_QUAD, `OCP_RST_APLL_FINE,
    `OCP_RST_DIFF_CTRL, `OCP_RST_DIFF_SEL, `OCP_RST_COMB_FINE, `OCP_RST_PAGE};
  logic [7:0] m [6] = DFT;
  logic [31:0] exp_q [$];
  logic rd_dp = 1'b0;
  logic [7:0] v;
  int n_errors = 0;
  int checked = 0;
  int cycles = 0;

  ocp_output_clock_phase_regs i_ocp_output_clock_phase_regs (
    .mclk_i, .sys_rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i,
    .hwdata_i, .hready_i(hreadyout_o), .hreadyout_o, .hresp_o, .hrdata_o,
    .quad_phase_o, .apll_trim_code_o, .apll_trim_o, .comb_trim_code_o,
    .comb_trim_o, .diff_oe_o, .diff_skew_o, .diff_skew_ps_o,
    .diff_freq_sel_o, .page_sel_o, .page_o, .page_reserved_o);

  // Free running 200 MHz clock.
  initial begin
    forever #2.5 mclk_i = ~mclk_i;
  end

  task automatic conclude;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Monitor: a read data phase ends on hready, so the oldest note is due.
  // The timeout lives here too, so a stuck bus still reaches the verdict.
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      conclude();
    end
    if (rd_dp && hreadyout_o === 1'b1) begin
      chk("hrdata", exp_q.pop_front(), hrdata_o);
      chk("hresp", `OCP_HRESP_OKAY, hresp_o);
    end
    if (sys_rst_i) begin
      rd_dp <= 1'b0;
    end else if (hreadyout_o === 1'b1) begin
      rd_dp <= hsel_i && htrans_i[1] && !hwrite_i;
    end
  end

  task automatic wait_rdy;
    do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
  endtask : wait_rdy

  // One single word transfer; the address phase is held until hready.
  task automatic xfer(input logic wr, input logic [7:0] idx,
                      input logic [31:0] wd);
    hsel_i <= 1'b1;
    haddr_i <= {2'b00, idx, 2'b00};
    htrans_i <= 2'b10;
    hwrite_i <= wr;
    wait_rdy();
    htrans_i <= 2'b00;
    hwdata_i <= wr ? wd : $urandom;
    wait_rdy();
  endtask : xfer

  // Upper lanes carry noise: the bank must keep only the low byte.
  task automatic put(input int k, input logic [7:0] d);
    m[k] = d;
    xfer(1'b1, IDX[k], {24'($urandom), d});
  endtask : put

  task automatic get(input int k);
    exp_q.push_back({24'h0, m[k]});
    xfer(1'b0, IDX[k], 32'h0);
  endtask : get

  function automatic ocp_page_t pg_of(input logic [7:0] p);
    case (p)
      8'h00: return OCP_PAGE_GENERAL;
      8'h01: return OCP_PAGE_OSC;
      8'h08: return OCP_PAGE_SYNC1HZ;
      8'h0a: return OCP_PAGE_TOD;
      8'h0f: return OCP_PAGE_INTSTAT;
      default: return OCP_PAGE_RESERVED;
    endcase
  endfunction : pg_of

  // Compares every clock control against the bench's register model.
  task automatic chk_ctl;
    repeat (1) @(posedge mclk_i);
    #1;
    chk("quad", 4'b0001 << m[0][1:0], quad_phase_o);
    chk("apll_code", m[1], apll_trim_code_o);
    chk("apll_trim", $signed(m[1]) * 1192, 32'(apll_trim_o));
    chk("diff_oe", m[2][1], diff_oe_o);
    chk("skew", m[2][7:6], diff_skew_o);
    chk("skew_ps", m[2][7:6] * 1600, diff_skew_ps_o);
    chk("freq", m[3][6:4], diff_freq_sel_o);
    chk("comb_code", m[4], comb_trim_code_o);
    chk("comb_trim", $signed(m[4]) * 1192, 32'(comb_trim_o));
    chk("page_sel", m[5], page_sel_o);
    chk("page", pg_of(m[5]), page_o);
    chk("page_rsv", pg_of(m[5]) == OCP_PAGE_RESERVED, page_reserved_o);
  endtask : chk_ctl

  task automatic get_all;
    for (int k = 0; k < 6; k++) begin
      get(k);
    end
  endtask : get_all

  // Main sequence.
  initial begin
    void'($urandom(32'h4829737d));
    repeat (12) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    @(posedge mclk_i);
    chk_ctl();
    get_all();
    $display("test reset_defaults done");
    for (int c = 0; c < 4; c++) begin
      put(0, 8'(c));
      get(0);
      chk_ctl();
    end
    $display("test quadrant done");
    for (int i = 0; i < 8; i++) begin
      v = (i < 4) ? 8'h80 >> (i * 2) : 8'($urandom);
      v = (i == 1) ? 8'h7f : (i == 2) ? 8'hff : v;
      put(1, v);
      put(4, ~v);
      get(1);
      get(4);
      chk_ctl();
    end
    $display("test fine_trims done");
    for (int i = 0; i < 8; i++) begin
      put(2, {i[2:1], 4'b1000, i[0], 1'b1});
      chk_ctl();
      get(2);
    end
    $display("test differential done");
    for (int f = 0; f < 8; f++) begin
      put(3, {1'b0, f[2:0], 4'h5});
      chk_ctl();
    end
    $display("test frequency done");
    for (int i = 0; i < 7; i++) begin
      v = (i == 5) ? {4'(1 + $urandom % 15), 4'($urandom)} : 8'($urandom);
      case (i)
        0: v = `OCP_PG_GENERAL;
        1: v = `OCP_PG_OSC;
        2: v = `OCP_PG_SYNC1HZ;
        3: v = `OCP_PG_TOD;
        4: v = `OCP_PG_INTSTAT;
        6: v = `OCP_PG_GENERAL;
        default: ;
      endcase
      put(5, v);
      chk_ctl();
    end
    $display("test pages done");
    // Unmapped places read as zero and swallow writes.
    xfer(1'b1, 8'h54, $urandom);
    xfer(1'b1, 8'h62, $urandom);
    exp_q.push_back(32'h0);
    xfer(1'b0, 8'h54, 32'h0);
    get_all();
    $display("test unmapped done");
    // Reset in mid-run must bring every register back to its default.
    put(0, 8'h03);
    sys_rst_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    m = DFT;
    @(posedge mclk_i);
    chk_ctl();
    get_all();
    $display("test second_reset done");
    repeat (2) @(posedge mclk_i);
    conclude();
  end

endmodule : output_clock_phase_regs_test
